// *** sslcs_board.sv ***
// Board controller model that releases the output stops once lock is shown.
`timescale 1ns/1ps
`default_nettype none
module sslcs_board (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lock_pin,
  input wire logic [1:0] run_req,
  output logic [1:0] output_stop_n
);
  logic seen_q;
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) seen_q <= 1'h0;
    else if (lock_pin) seen_q <= 1'h1;
  end
  // Stops stay asserted until lock has been seen once.
  assign output_stop_n = run_req & {2{seen_q}};
endmodule
`default_nettype wire

// *** sslcs_pkg.sv ***
// Shared constants for the synthesizer startup, lock and clock-stop control block.
`default_nettype none
package sslcs_pkg;
  localparam int unsigned SSLCS_M_W = 10;
  localparam int unsigned SSLCS_NA_W = 3;
  localparam int unsigned SSLCS_DIV_CNT_W = 7;
  localparam int unsigned SSLCS_LOCK_CNT_W = 16;
  // Divider setup after master reset release (pins floating).
  localparam logic [9:0] SSLCS_M_DEF = 10'h1f4;
  localparam logic SSLCS_P_DEF = 1'h0;
  localparam logic [2:0] SSLCS_NA_DEF = 3'h2;
  localparam logic SSLCS_NB_DEF = 1'h0;
  // Largest valid post-divider code (divide by 64).
  localparam logic [2:0] SSLCS_NA_MAX = 3'h5;
  // Default lock qualification delay in clock cycles.
  localparam int unsigned SSLCS_LOCK_DELAY_DEF = 1024;
endpackage
`default_nettype wire

// *** sslcs_top.sv ***
// Synthesizer divider configuration, lock indication and synchronous output stop.
`timescale 1ns/1ps
`default_nettype none

module sslcs_top #(
  parameter int unsigned LOCK_DELAY = sslcs_pkg::SSLCS_LOCK_DELAY_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic parallel_config_select_n,
  input wire logic [sslcs_pkg::SSLCS_M_W-1:0] pin_feedback_div,
  input wire logic [sslcs_pkg::SSLCS_NA_W-1:0] pin_primary_post_divider,
  input wire logic pin_secondary_half_rate_select,
  input wire logic pin_predivider,
  input wire logic [sslcs_pkg::SSLCS_M_W-1:0] ser_feedback_div,
  input wire logic [sslcs_pkg::SSLCS_NA_W-1:0] ser_primary_post_divider,
  input wire logic ser_secondary_half_rate_select,
  input wire logic ser_predivider,
  input wire logic ser_load,
  input wire logic step_up_command,
  input wire logic step_down_command,
  input wire logic pll_lock_detect,
  input wire logic [1:0] output_stop_n,
  output logic [sslcs_pkg::SSLCS_M_W-1:0] feedback_div,
  output logic [sslcs_pkg::SSLCS_NA_W-1:0] primary_post_divider,
  output logic secondary_half_rate_select,
  output logic predivider,
  output logic lock_pin,
  output logic lock_status,
  output logic first_output,
  output logic second_output
);
  import sslcs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 1 + SSLCS_M_W + SSLCS_NA_W + 1 + 1 + 1 + 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'h1, {(SYNC_W-3){1'h0}}, 2'h0};
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  wire [SYNC_W-1:0] sync_in = {parallel_config_select_n, pin_feedback_div,
    pin_primary_post_divider, pin_secondary_half_rate_select, pin_predivider,
    pll_lock_detect, output_stop_n};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  wire serial_mode = sync2_q[SYNC_W-1];
  wire [SSLCS_M_W-1:0] pm_s = sync2_q[SYNC_W-2 -: SSLCS_M_W];
  wire [SSLCS_NA_W-1:0] pna_s = sync2_q[7:5];
  wire pnb_s = sync2_q[4];
  wire pp_s = sync2_q[3];
  wire lock_s = sync2_q[2];
  wire [1:0] run_s = sync2_q[1:0];

  // ----------------------------------------------------------------
  // Divider configuration
  // ----------------------------------------------------------------
  logic [SSLCS_M_W-1:0] m_q, m_d;
  logic [SSLCS_NA_W-1:0] na_q, na_d;
  logic nb_q, nb_d, p_q, p_d;

  // Parallel pins win; serial load beats a step in the same cycle.
  always_comb begin
    m_d = m_q;
    na_d = na_q;
    nb_d = nb_q;
    p_d = p_q;
    if (!serial_mode) begin
      m_d = pm_s;
      na_d = pna_s;
      nb_d = pnb_s;
      p_d = pp_s;
    end else if (ser_load) begin
      m_d = ser_feedback_div;
      na_d = ser_primary_post_divider;
      nb_d = ser_secondary_half_rate_select;
      p_d = ser_predivider;
    end else if (step_up_command && !step_down_command) begin
      m_d = m_q + 10'h001;
    end else if (step_down_command && !step_up_command) begin
      m_d = m_q - 10'h001;
    end
  end

  // Reset values are the default setup, in place when master reset rises.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m_q <= SSLCS_M_DEF;
      na_q <= SSLCS_NA_DEF;
      nb_q <= SSLCS_NB_DEF;
      p_q <= SSLCS_P_DEF;
    end else begin
      m_q <= m_d;
      na_q <= na_d;
      nb_q <= nb_d;
      p_q <= p_d;
    end
  end

  assign feedback_div = m_q;
  assign primary_post_divider = na_q;
  assign secondary_half_rate_select = nb_q;
  assign predivider = p_q;

  // ----------------------------------------------------------------
  // Lock detection
  // ----------------------------------------------------------------
  logic [SSLCS_LOCK_CNT_W-1:0] lock_cnt_q;
  logic lock_q;
  wire loop_change = (m_d != m_q) || (p_d != p_q);
  wire qualify = lock_s && !loop_change;
  wire cnt_done = lock_cnt_q == SSLCS_LOCK_CNT_W'(LOCK_DELAY - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_q <= '0;
      lock_q <= 1'h0;
    end else if (!qualify) begin
      lock_cnt_q <= '0;
      lock_q <= 1'h0;
    end else if (!lock_q) begin
      lock_cnt_q <= cnt_done ? lock_cnt_q : lock_cnt_q + {{(SSLCS_LOCK_CNT_W-1){1'h0}}, 1'h1};
      lock_q <= cnt_done;
    end
  end

  assign lock_pin = lock_q;
  assign lock_status = lock_q;

  // ----------------------------------------------------------------
  // Output divider and synchronous stop
  // ----------------------------------------------------------------
  logic [SSLCS_DIV_CNT_W-1:0] div_cnt_q;
  wire [SSLCS_DIV_CNT_W-1:0] div_cnt_d = div_cnt_q + 7'h01;
  wire [2:0] na_eff = (na_q > SSLCS_NA_MAX) ? SSLCS_NA_MAX : na_q;
  wire raw_a = div_cnt_d[na_eff];
  wire raw_b = nb_q ? div_cnt_d[na_eff + 3'h1] : raw_a;
  wire [1:0] raw_d = {raw_b, raw_a};
  logic [1:0] en_q;
  logic [1:0] out_q;

  // Each enable moves only while its output is low, so pulses stay whole.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_stop
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          en_q[gi] <= 1'h0;
          out_q[gi] <= 1'h0;
        end else begin
          en_q[gi] <= raw_d[gi] ? en_q[gi] : run_s[gi];
          out_q[gi] <= raw_d[gi] & (raw_d[gi] ? en_q[gi] : run_s[gi]);
        end
      end
    end
  endgenerate

  // One shared counter keeps coincident edges of both outputs aligned.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  assign first_output = out_q[0];
  assign second_output = out_q[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_lock_pair_same: assert property (lock_pin == lock_status)
    else $error("lock pin and status differ");
  chk_lock_fast_drop: assert property (!lock_s |=> !lock_pin)
    else $error("lock not dropped after loss");
  chk_lock_change_drop: assert property (loop_change |=> !lock_pin)
    else $error("lock held across divider change");
  chk_lock_delay_count: assert property ($rose(lock_pin) |->
    $past(lock_cnt_q) == SSLCS_LOCK_CNT_W'(LOCK_DELAY - 1) && $past(qualify))
    else $error("lock rose without full delay");
  chk_lock_qual_run: assert property (lock_pin |-> $past(lock_s))
    else $error("lock shown without qualifying input");
  chk_par_follow_pins: assert property (!serial_mode |=>
    feedback_div == $past(pm_s) && primary_post_divider == $past(pna_s))
    else $error("dividers not following pins");
  chk_ser_load_take: assert property (serial_mode && ser_load |=>
    feedback_div == $past(ser_feedback_div) && predivider == $past(ser_predivider))
    else $error("serial load not taken");
  chk_stop_hold_low: assert property (!en_q[0] |-> !first_output)
    else $error("stopped first output not low");
  chk_stop_no_runt: assert property ($rose(first_output) && na_eff != 3'h0 &&
    $stable(na_eff) |=> first_output)
    else $error("first output pulse shortened");
  chk_edge_aligned: assert property (!nb_q && en_q == 2'h3 |->
    first_output == second_output)
    else $error("outputs misaligned");

  cov_lock_gained: cover property ($rose(lock_pin));
  cov_relock_after_step: cover property (serial_mode && step_down_command ##[1:1000]
    $rose(lock_pin));
  cov_stop_release: cover property ($rose(en_q[0]) ##[1:200] $rose(first_output));
  cov_half_rate_run: cover property (nb_q && en_q == 2'h3 && $rose(second_output));
endmodule

`default_nettype wire

// *** sslcs_top_bench.sv ***
// Self-checking bench for the synthesizer control block.
`timescale 1ns/1ps
`default_nettype none
module sslcs_top_bench;
  import sslcs_pkg::*;
  logic clk = 0, arst_n = 0, sel_n = 1, nb = 0, p = 0, s_nb = 0, s_p = 0, ld = 0, up = 0, dn = 0;
  logic det = 0, nb_o, p_o, lk, lks, qa, qb;
  logic [9:0] m = 0, s_m = 0, m_o;
  logic [2:0] na = 0, s_na = 0, na_o, cur_na = 3'h2;
  logic [1:0] run = 0, stp;
  int n_errors = 0, n_checks = 0, hi_n = 0, rb = 0;
  always #12.5 clk = ~clk;
  sslcs_top #(.LOCK_DELAY(8)) dut (.clk(clk), .arst_n(arst_n),
    .parallel_config_select_n(sel_n), .pin_feedback_div(m), .pin_primary_post_divider(na),
    .pin_secondary_half_rate_select(nb), .pin_predivider(p), .ser_feedback_div(s_m),
    .ser_primary_post_divider(s_na), .ser_secondary_half_rate_select(s_nb),
    .ser_predivider(s_p), .ser_load(ld), .step_up_command(up), .step_down_command(dn),
    .pll_lock_detect(det), .output_stop_n(stp), .feedback_div(m_o),
    .primary_post_divider(na_o), .secondary_half_rate_select(nb_o), .predivider(p_o),
    .lock_pin(lk), .lock_status(lks), .first_output(qa), .second_output(qb));
  sslcs_board board (.clk(clk), .arst_n(arst_n), .lock_pin(lk), .run_req(run),
    .output_stop_n(stp));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_lock(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && lk !== v; i++) cyc(1);
    chk(lk, v);
    chk(lks, lk);
    if (lk !== v) end_sim();
  endtask
  task automatic t_defaults();
    chk(m_o, SSLCS_M_DEF);
    chk({na_o, nb_o, p_o}, {SSLCS_NA_DEF, SSLCS_NB_DEF, SSLCS_P_DEF});
    chk({lk, qa, qb}, 3'h0);
  endtask
  task automatic t_serial();
    s_m = 10'h0aa; s_na = 3'h0; s_nb = 1; s_p = 1; ld = 1;
    cyc(1);
    ld = 0;
    chk({m_o, na_o, nb_o, p_o}, {10'h0aa, 3'h0, 2'h3});
    up = 1;
    cyc(1);
    up = 0;
    chk(m_o, 10'h0ab);
    dn = 1;
    cyc(1);
    dn = 0;
    chk(m_o, 10'h0aa);
    up = 1; dn = 1;
    cyc(1);
    up = 0; dn = 0;
    chk(m_o, 10'h0aa);
    s_na = 3'h2; s_nb = 0; ld = 1;
    cyc(1);
    ld = 0;
  endtask
  task automatic t_lock();
    det = 1;
    cyc(9);
    chk(lk, 1'h0);
    wait_lock(1, 1);
    det = 0;
    wait_lock(0, 4);
    det = 1;
    wait_lock(1, 20);
    up = 1;
    cyc(1);
    up = 0;
    wait_lock(0, 3);
    wait_lock(1, 20);
  endtask
  task automatic t_stop();
    run = 2'h3;
    cyc(40);
    for (int i = 0; i < 16; i++) begin
      chk(qa, qb);
      cyc(1);
    end
    run = 2'h2;
    cyc(12);
    rb = 0;
    for (int i = 0; i < 24; i++) begin
      chk(qa, 1'h0);
      rb += qb;
      cyc(1);
    end
    chk(rb > 0, 1'h1);
    run = 2'h3;
    cyc(40);
    for (int i = 0; i < 16; i++) begin
      chk(qa, qb);
      cyc(1);
    end
  endtask
  task automatic t_parallel();
    run = 0;
    cyc(12);
    sel_n = 0; m = 10'h155; na = 3'h1; nb = 1; p = 1; cur_na = 3'h1;
    cyc(4);
    chk({m_o, na_o, nb_o, p_o}, {10'h155, 3'h1, 2'h3});
    s_m = 10'h0f0; ld = 1;
    cyc(1);
    ld = 0;
    chk(m_o, 10'h155);
    m = 10'h0aa;
    cyc(4);
    chk(m_o, 10'h0aa);
    sel_n = 1;
    m = 10'h123;
    cyc(4);
    chk({m_o, na_o}, {10'h0aa, 3'h1});
  endtask
  task automatic t_reset_mid();
    int i;
    run = 2'h3;
    for (i = 0; i < 80 && qa !== 1'h1; i++) cyc(1);
    chk(qa, 1'h1);
    if (qa !== 1'h1) end_sim();
    arst_n = 0;
    #1 chk(qa, 1'h0);
    cur_na = 3'h2;
    cyc(2);
    arst_n = 1;
    cyc(1);
    t_defaults();
  endtask
  always @(negedge clk) begin
    if (!arst_n) hi_n = 0;
    else if (qa === 1'h1) hi_n++;
    else if (hi_n != 0) begin
      chk(16'(hi_n), 16'h1 << cur_na);
      hi_n = 0;
    end
  end
  initial begin
    cyc(6);
    arst_n = 1;
    cyc(1);
    t_defaults();
    t_serial();
    t_lock();
    t_stop();
    t_parallel();
    wait_lock(1, 30);
    t_reset_mid();
    end_sim();
  end
endmodule
`default_nettype wire
